/* include/mia_map.vh */
`ifndef MIA_MAP_VH
`define MIA_MAP_VH

// register byte offsets on the bus
`define MIA_REG_CMD     8'h00
`define MIA_REG_STATUS  8'h04
`define MIA_REG_ACC     8'h08
`define MIA_REG_PC      8'h0c
`define MIA_REG_MADDR   8'h10
`define MIA_REG_MDATA   8'h14
`define MIA_REG_TPTR    8'h18
`define MIA_REG_TDATA   8'h1c
`define MIA_REG_CYCLES  8'h20
`define MIA_REG_TBLH    8'h24

// command word fields
`define MIA_OP_HI       6
`define MIA_OP_LO       0
`define MIA_BIT_HI      10
`define MIA_BIT_LO      8
`define MIA_JHI_HI      11
`define MIA_JHI_LO      8
`define MIA_ADDR_HI     23
`define MIA_ADDR_LO     16
`define MIA_IMM_HI      31
`define MIA_IMM_LO      24

// opcode groups, op[5:3]
`define MIA_GRP_ARITH   3'h0
`define MIA_GRP_LOGIC   3'h1
`define MIA_GRP_UNARY   3'h2
`define MIA_GRP_MOVE    3'h3
`define MIA_GRP_BIT     3'h4
`define MIA_GRP_SKIP    3'h5
`define MIA_GRP_FLOW    3'h6

// status register bit positions
`define MIA_ST_Z        0
`define MIA_ST_C        1
`define MIA_ST_AC       2
`define MIA_ST_OV       3
`define MIA_ST_SC       4
`define MIA_ST_CZ       5
`define MIA_ST_BUSY     8

// sizes, reset values and timing
`define MIA_PC_W        12
`define MIA_PC_RESET    12'h000
`define MIA_STACK_DEPTH 8
`define MIA_MEM_DEPTH   256
`define MIA_TBL_DEPTH   256
`define MIA_PCL_ADDR    8'h06
`define MIA_CLK_PER_IC  4
`define MIA_BCD_LIMIT   4'h9

`endif

/* src/mia_core.v */
// Notes on behaviour
// - one instruction cycle is four mclk periods; timing counts those.
// - most take one cycle; jump, call, return, table read take two.
// - writing the program counter low byte adds one instruction cycle, except by table read.
// - skip costs one cycle, plus one more when the skip is taken.
// - add carries above 255; subtract flags borrow in carry below 0.
// - increment/decrement change byte by one, to memory or working, zero.
// - and, or, xor with memory or immediate update only zero flag.
// - plain rotates move byte one place circularly, flags untouched.
// - rotate through carry swaps outgoing bit with carry; carry only.
// - call saves next address, exit resumes there; jump saves nothing.
// - skips test a byte or a bit and skip the next instruction.
// - bit set/clear addresses bits 0 to 7, others kept unchanged.
// - table read moves program memory data into data memory.
// - every add updates zero, carry, aux carry, overflow, signed.
// - every subtract updates those five plus the carry-zero flag.
// - memory-destination variants write memory, others the working reg.
// - decimal adjust fixes working reg into memory, carry flag only.
// - complement inverts the byte, to memory or working, zero only.
// - base group reaches data memory sector 0 only.
//
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
`include "mia_map.vh"

module mia_core (
    input  wire        mclk,
    input  wire        rst,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp
);

    localparam [1:0] S_IDLE = 2'b01;
    localparam [1:0] S_EXEC = 2'b10;

    reg  [1:0]             state;
    reg  [3:0]             cnt;
    reg  [31:0]            cmd;
    reg  [7:0]             acc;
    reg  [`MIA_PC_W-1:0]   pc;
    reg  [2:0]             sp;
    reg  [7:0]             maddr;
    reg  [7:0]             tptr;
    reg  [7:0]             tblh;
    reg  [1:0]             last_cyc;
    reg                    fz;
    reg                    fc;
    reg                    fac;
    reg                    fov;
    reg                    fsc;
    reg                    fcz;
    reg                    pend;
    reg                    pend_wr;
    reg                    pend_hit;
    reg  [7:0]             pend_addr;
    reg  [7:0]             mem [0:`MIA_MEM_DEPTH-1];
    reg  [15:0]            tbl [0:`MIA_TBL_DEPTH-1];
    reg  [`MIA_PC_W-1:0]   stack [0:`MIA_STACK_DEPTH-1];

    reg  [7:0]             r;
    reg  [8:0]             t9;
    reg  [8:0]             t9b;
    reg  [4:0]             t5;
    reg                    cout;
    reg                    h;
    reg                    v;
    reg                    wr_acc;
    reg                    wr_mem;
    reg                    upd_z;
    reg                    upd_c;
    reg                    upd_arith;
    reg                    upd_cz;
    reg                    skip;
    reg                    lo6;
    reg                    hi6;
    reg  [1:0]             ncyc;
    reg  [31:0]            rd_mux;

    wire                   busy     = state[1];
    wire [6:0]             op       = cmd[`MIA_OP_HI:`MIA_OP_LO];
    wire [2:0]             grp      = op[5:3];
    wire [1:0]             sub      = op[2:1];
    wire                   dst      = op[0];
    wire                   mods     = op[6];
    wire [2:0]             bit_idx  = cmd[`MIA_BIT_HI:`MIA_BIT_LO];
    // 8-bit operand address: only sector 0 is reachable by this group
    wire [7:0]             m        = cmd[`MIA_ADDR_HI:`MIA_ADDR_LO];
    wire [7:0]             imm      = cmd[`MIA_IMM_HI:`MIA_IMM_LO];
    wire [`MIA_PC_W-1:0]   target   = {cmd[`MIA_JHI_HI:`MIA_JHI_LO], imm};
    wire [`MIA_PC_W-1:0]   pc_inc   = pc + 12'h001;
    wire [7:0]             bit_mask = 8'h01 << bit_idx;
    wire [15:0]            tword    = tbl[tptr];
    wire [7:0]             mval;
    wire [7:0]             bsrc;
    wire                   commit;
    wire                   bus_we;
    wire [3:0]             last_cnt;

    function is_pcl;
        input [7:0] a;
        begin
            is_pcl = (a == `MIA_PCL_ADDR);
        end
    endfunction

    // the low program counter byte is visible as a data memory location
    assign mval     = is_pcl(m) ? pc[7:0] : mem[m];
    assign bsrc     = mods ? imm : mval;
    assign last_cnt = {ncyc, 2'b00} - 4'h1;
    assign commit   = busy && (cnt == last_cnt);
    // writes wait while an instruction runs, so nothing races the commit
    assign bus_we   = pend && pend_wr && pend_hit && !busy;

    always @* begin
        r         = 8'h00;
        t9        = 9'h000;
        t9b       = 9'h000;
        t5        = 5'h00;
        cout      = 1'b0;
        h         = 1'b0;
        v         = 1'b0;
        wr_acc    = 1'b0;
        wr_mem    = 1'b0;
        upd_z     = 1'b0;
        upd_c     = 1'b0;
        upd_arith = 1'b0;
        upd_cz    = 1'b0;
        skip      = 1'b0;
        lo6       = 1'b0;
        hi6       = 1'b0;
        case (grp)
            `MIA_GRP_ARITH: begin
                if (!sub[1]) begin
                    t9 = {1'b0, acc} + {1'b0, bsrc} + {8'h00, sub[0] & fc};
                    t5 = {1'b0, acc[3:0]} + {1'b0, bsrc[3:0]}
                         + {4'h0, sub[0] & fc};
                    v  = (acc[7] == bsrc[7]) && (t9[7] != acc[7]);
                end else begin
                    // carry set means a borrow was taken
                    t9 = {1'b0, acc} - {1'b0, bsrc} - {8'h00, sub[0] & fc};
                    t5 = {1'b0, acc[3:0]} - {1'b0, bsrc[3:0]}
                         - {4'h0, sub[0] & fc};
                    v  = (acc[7] != bsrc[7]) && (t9[7] != acc[7]);
                    upd_cz = 1'b1;
                end
                r         = t9[7:0];
                cout      = t9[8];
                h         = t5[4];
                upd_arith = 1'b1;
                wr_mem    = dst && !mods;
                wr_acc    = !(dst && !mods);
            end
            `MIA_GRP_LOGIC: begin
                case (sub)
                    2'd0:    r = acc & bsrc;
                    2'd1:    r = acc | bsrc;
                    2'd2:    r = acc ^ bsrc;
                    default: r = ~mval;
                endcase
                upd_z  = 1'b1;
                wr_mem = (sub == 2'd3) ? dst : (dst && !mods);
                wr_acc = !wr_mem;
            end
            `MIA_GRP_UNARY: begin
                case (sub)
                    2'd0: begin
                        r     = mval + 8'h01;
                        upd_z = 1'b1;
                    end
                    2'd1: begin
                        r     = mval - 8'h01;
                        upd_z = 1'b1;
                    end
                    2'd2: begin
                        r     = {mods ? fc : mval[0], mval[7:1]};
                        cout  = mval[0];
                        upd_c = mods;
                    end
                    default: begin
                        r     = {mval[6:0], mods ? fc : mval[7]};
                        cout  = mval[7];
                        upd_c = mods;
                    end
                endcase
                wr_mem = dst;
                wr_acc = !dst;
            end
            `MIA_GRP_MOVE: begin
                case (sub)
                    2'd0: begin
                        r      = mods ? imm : (dst ? acc : mval);
                        wr_mem = dst && !mods;
                        wr_acc = !(dst && !mods);
                    end
                    2'd1: begin
                        r      = mods ? 8'hff : 8'h00;
                        wr_mem = 1'b1;
                    end
                    2'd2: begin
                        r      = {mval[3:0], mval[7:4]};
                        wr_mem = dst;
                        wr_acc = !dst;
                    end
                    default: begin
                        lo6    = (acc[3:0] > `MIA_BCD_LIMIT) || fac;
                        t9     = {1'b0, acc} + (lo6 ? 9'h006 : 9'h000);
                        hi6    = (t9[7:4] > `MIA_BCD_LIMIT) || fc || t9[8];
                        t9b    = t9 + (hi6 ? 9'h060 : 9'h000);
                        r      = t9b[7:0];
                        cout   = hi6;
                        upd_c  = 1'b1;
                        wr_mem = 1'b1;
                    end
                endcase
            end
            `MIA_GRP_BIT: begin
                case (sub)
                    2'd0: begin
                        r      = mval & ~bit_mask;
                        wr_mem = 1'b1;
                    end
                    2'd1: begin
                        r      = mval | bit_mask;
                        wr_mem = 1'b1;
                    end
                    2'd2:    skip = !(|(mval & bit_mask));
                    default: skip = |(mval & bit_mask);
                endcase
            end
            `MIA_GRP_SKIP: begin
                case (sub)
                    2'd0: begin
                        r      = mval;
                        skip   = (mval == 8'h00);
                        wr_acc = !dst;
                    end
                    2'd1:    skip = (mval != 8'h00);
                    2'd2: begin
                        r      = mval + 8'h01;
                        skip   = (r == 8'h00);
                        wr_mem = dst;
                        wr_acc = !dst;
                    end
                    default: begin
                        r      = mval - 8'h01;
                        skip   = (r == 8'h00);
                        wr_mem = dst;
                        wr_acc = !dst;
                    end
                endcase
            end
            `MIA_GRP_FLOW: begin
                if (sub == 2'd2) begin
                    r      = imm;
                    wr_acc = mods;
                end else if (sub == 2'd3) begin
                    r      = tword[7:0];
                    wr_mem = 1'b1;
                end
            end
            default: r = 8'h00;
        endcase
        ncyc = 2'd1 + {1'b0, grp == `MIA_GRP_FLOW}
               + {1'b0, skip}
               + {1'b0, wr_mem && is_pcl(m) && grp != `MIA_GRP_FLOW};
    end

    // bus slave: every transfer gets one wait state so hrdata is registered; writes wait longer while busy
    always @(posedge mclk) begin
        if (rst) begin
            pend      <= 1'b0;
            pend_wr   <= 1'b0;
            pend_hit  <= 1'b0;
            pend_addr <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
        end else if (!pend) begin
            if (hsel && htrans[1] && hready) begin
                pend      <= 1'b1;
                pend_wr   <= hwrite;
                pend_hit  <= (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'b00);
                pend_addr <= haddr[7:0];
                hreadyout <= 1'b0;
            end
        end else if (!(pend_wr && busy)) begin
            pend      <= 1'b0;
            hreadyout <= 1'b1;
            hrdata    <= (pend_wr || !pend_hit) ? 32'h0000_0000 : rd_mux;
        end
    end

    always @* begin
        case (pend_addr)
            `MIA_REG_CMD:    rd_mux = cmd;
            `MIA_REG_STATUS: rd_mux = {23'h0, busy, 2'b00, fcz, fsc,
                                       fov, fac, fc, fz};
            `MIA_REG_ACC:    rd_mux = {24'h0, acc};
            `MIA_REG_PC:     rd_mux = {20'h0, pc};
            `MIA_REG_MADDR:  rd_mux = {24'h0, maddr};
            `MIA_REG_MDATA:  rd_mux = {24'h0, is_pcl(maddr) ? pc[7:0]
                                                            : mem[maddr]};
            `MIA_REG_TPTR:   rd_mux = {24'h0, tptr};
            `MIA_REG_TDATA:  rd_mux = {16'h0, tword};
            `MIA_REG_CYCLES: rd_mux = {30'h0, last_cyc};
            `MIA_REG_TBLH:   rd_mux = {24'h0, tblh};
            default:         rd_mux = 32'h0000_0000;
        endcase
    end

    // data and table memories hold no reset; their contents start unknown
    always @(posedge mclk) begin
        if (commit && wr_mem && !is_pcl(m)) begin
            mem[m] <= r;
        end else if (bus_we && pend_addr == `MIA_REG_MDATA &&
                     !is_pcl(maddr)) begin
            mem[maddr] <= hwdata[7:0];
        end
        if (bus_we && pend_addr == `MIA_REG_TDATA) begin
            tbl[tptr] <= hwdata[15:0];
        end
        if (commit && grp == `MIA_GRP_FLOW && sub == 2'd1) begin
            stack[sp] <= pc_inc;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            state    <= S_IDLE;
            cnt      <= 4'h0;
            cmd      <= 32'h0000_0000;
            acc      <= 8'h00;
            pc       <= `MIA_PC_RESET;
            sp       <= 3'd0;
            maddr    <= 8'h00;
            tptr     <= 8'h00;
            tblh     <= 8'h00;
            last_cyc <= 2'd0;
            fz       <= 1'b0;
            fc       <= 1'b0;
            fac      <= 1'b0;
            fov      <= 1'b0;
            fsc      <= 1'b0;
            fcz      <= 1'b0;
        end else begin
            case (state)
                S_IDLE: begin
                    cnt <= 4'h0;
                    if (bus_we) begin
                        case (pend_addr)
                            `MIA_REG_CMD: begin
                                cmd   <= hwdata;
                                state <= S_EXEC;
                            end
                            `MIA_REG_STATUS: begin
                                fz  <= hwdata[`MIA_ST_Z];
                                fc  <= hwdata[`MIA_ST_C];
                                fac <= hwdata[`MIA_ST_AC];
                                fov <= hwdata[`MIA_ST_OV];
                                fsc <= hwdata[`MIA_ST_SC];
                                fcz <= hwdata[`MIA_ST_CZ];
                            end
                            `MIA_REG_ACC:   acc   <= hwdata[7:0];
                            `MIA_REG_MADDR: maddr <= hwdata[7:0];
                            `MIA_REG_MDATA: begin
                                if (is_pcl(maddr)) begin
                                    pc <= {pc[`MIA_PC_W-1:8], hwdata[7:0]};
                                end
                            end
                            `MIA_REG_TPTR:  tptr  <= hwdata[7:0];
                            default:        cnt   <= 4'h0;
                        endcase
                    end
                end
                S_EXEC: begin
                    cnt <= cnt + 4'h1;
                    if (commit) begin
                        state    <= S_IDLE;
                        cnt      <= 4'h0;
                        last_cyc <= ncyc;
                        if (wr_acc) begin
                            acc <= r;
                        end
                        if (upd_z) begin
                            fz <= (r == 8'h00);
                        end
                        if (upd_c) begin
                            fc <= cout;
                        end
                        if (upd_arith) begin
                            fz  <= (r == 8'h00);
                            fc  <= cout;
                            fac <= h;
                            fov <= v;
                            fsc <= v ^ r[7];
                        end
                        if (upd_cz) begin
                            fcz <= (r == 8'h00) && (!sub[0] || fcz);
                        end
                        if (grp == `MIA_GRP_FLOW && sub == 2'd3) begin
                            tblh <= tword[15:8];
                        end
                        if (grp == `MIA_GRP_FLOW && sub[1] == 1'b0) begin
                            pc <= target;
                            if (sub[0]) begin
                                sp <= sp + 3'd1;
                            end
                        end else if (grp == `MIA_GRP_FLOW && sub == 2'd2) begin
                            pc <= stack[sp - 3'd1];
                            sp <= sp - 3'd1;
                        end else if (wr_mem && is_pcl(m)) begin
                            pc <= {pc[`MIA_PC_W-1:8], r};
                        end else begin
                            pc <= pc_inc + {11'h000, skip};
                        end
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

endmodule // mia_core

/* tb/mia_core_props.sv */
`include "mia_map.vh"
module mia_core_props (
    input wire        mclk,
    input wire        rst,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [2:0]  hsize,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire take = hsel && htrans[1] && hready;
    reg  pend;
    wire cmd_done = pend && hreadyout;

    // remembers a command write until its data phase completes
    always @(posedge mclk) begin
        if (rst)
            pend <= 1'b0;
        else if (take)
            pend <= hwrite && haddr[7:0] == `MIA_REG_CMD;
        else if (hreadyout)
            pend <= 1'b0;
    end

    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("response other than okay");
    chk_reset_idle: assert property ($fell(rst) |-> hreadyout
        && hrdata == 32'h0) else $error("bus not idle after reset");
    chk_take_waits: assert property (take |=> !hreadyout)
        else $error("no wait state after transfer");
    chk_read_fast: assert property (take && !hwrite
        |=> !hreadyout ##1 hreadyout) else $error("read waited too long");
    chk_wait_bound: assert property ($fell(hreadyout)
        |-> ##[1:14] hreadyout) else $error("wait state too long");
    chk_rdata_hold: assert property (!hreadyout
        |-> $stable(hrdata)) else $error("read data moved in wait");
    chk_idle_ready: assert property (hreadyout && !take
        |=> hreadyout) else $error("ready dropped while idle");
    chk_busy_stall: assert property (cmd_done ##1 (take && hwrite)
        |=> !hreadyout [*2]) else $error("write not held by busy core");

    cov_read: cover property (take && !hwrite);
    cov_cmd: cover property (cmd_done);
    cov_stall: cover property (!hreadyout [*4]);
endmodule // mia_core_props

bind mia_core mia_core_props i_mia_core_props (.mclk(mclk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp));

/* tb/tb_mia_core.sv */
`include "mia_map.vh"
module tb_mia_core;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk;
    logic        rst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    wire  [31:0] hrdata;
    wire         hreadyout;
    wire         hresp;
    int          error_cnt = 0;
    int          compares = 0;
    int          cyc = 0;
    int          k;
    logic [15:0] lf = 16'h0063;
    logic [11:0] pc = 12'h000;
    logic [31:0] rd;
    logic [2:0]  g;
    logic [1:0]  s;
    logic        md;
    logic        dst;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [7:0]  op;
    logic [5:0]  f;
    logic [13:0] e;

    mia_core i_mia_core (.mclk(mclk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp));

    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    function automatic logic [31:0] cmdw(input int md, g, s, d, bt, m, im);
        return {8'(im), 8'(m), 4'h0, 4'(bt), 1'b0, 1'(md), 3'(g), 2'(s),
            1'(d)};
    endfunction

    // returns {flags, result}; flags bit0 zero up to bit5 carry-zero
    function automatic logic [13:0] ref_op(input logic [2:0] g,
        input logic [1:0] s, input logic md, input logic [7:0] a, b,
        input logic [5:0] f);
        logic [8:0] t;
        logic [7:0] r;
        logic       ci;
        ci = s[0] & f[1];
        r = 8'h00;
        if (g == 3'h0) begin
            t = s[1] ? a - b - ci : a + b + ci;
            r = t[7:0];
            f[1] = t[8];
            if (s[1]) begin
                f[2] = {1'b0, a[3:0]} < {1'b0, b[3:0]} + ci;
                f[3] = a[7] != b[7] && r[7] != a[7];
                f[5] = r == 8'h00 && (!s[0] || f[5]);
            end else begin
                f[2] = a[3:0] + b[3:0] + ci > 5'h0f;
                f[3] = a[7] == b[7] && r[7] != a[7];
            end
            f[4] = f[3] ^ r[7];
        end else if (g == 3'h1)
            r = s == 0 ? a & b : s == 1 ? a | b : s == 2 ? a ^ b : ~b;
        else if (s[1]) begin
            r = s[0] ? {b[6:0], md ? f[1] : b[7]} : {md ? f[1] : b[0], b[7:1]};
            if (md)
                f[1] = s[0] ? b[7] : b[0];
        end else
            r = s[0] ? b - 8'h01 : b + 8'h01;
        if (g != 3'h2 || !s[1])
            f[0] = r == 8'h00;
        return {f, r};
    endfunction

    task automatic check(input logic [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task tally_and_finish;
        $display("compares=%0d mismatches=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // one single transfer, entered just after a rising edge
    task automatic xfer(input logic w, input logic [7:0] ad,
        input logic [31:0] d);
        k = 0;
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, ad};
        do begin @(posedge mclk); k++; end while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do begin @(posedge mclk); k++; end while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        xfer(1'b1, ad, d);
    endtask

    task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp);
        xfer(1'b0, ad, 32'h0);
        check(rd, exp);
    endtask

    // the write after a command stalls until the instruction commits
    task automatic run(input logic [31:0] c, n, input logic [11:0] np);
        wr(`MIA_REG_CMD, c);
        wr(`MIA_REG_TPTR, 32'h0);
        check(k >= 4 * n && k <= 4 * n + 2, 32'h1);
        rdchk(`MIA_REG_CYCLES, n);
        rdchk(`MIA_REG_PC, {20'h0, np});
        pc = np;
    endtask

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            tally_and_finish;
        end
    end

    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rdchk(`MIA_REG_ACC, 32'h0);
        rdchk(`MIA_REG_PC, 32'h0);
        rdchk(8'h80, 32'h0);
        for (int i = 0; i < 48; i++) begin
            lf = nxt(lf);
            g = 3'(lf[15:8] % 3);
            {f, dst, md, s} = lf[9:0];
            lf = nxt(lf);
            {a, b} = lf;
            if (i < 2) begin
                {g, s, md} = {3'h0, i[0], 2'b00};
                a = i[0] ? 8'h00 : 8'hff;
                b = 8'h01;
            end
            if (g == 3'h1 && s == 2'h3)
                md = 1'b0;
            lf = nxt(lf);
            op = (md && g != 3'h2) ? lf[15:8] : b;
            wr(`MIA_REG_ACC, {24'h0, a});
            wr(`MIA_REG_STATUS, {26'h0, f});
            wr(`MIA_REG_MADDR, {24'h0, 1'b1, lf[6:0]});
            wr(`MIA_REG_MDATA, {24'h0, b});
            e = ref_op(g, s, md, a, op, f);
            run(cmdw(md, g, s, dst, 0, {1'b1, lf[6:0]}, lf[15:8]), 1,
                pc + 12'h001);
            // immediate forms have no memory destination
            dst = dst && (g == 3'h2 || !md);
            rdchk(`MIA_REG_ACC, {24'h0, dst ? a : e[7:0]});
            rdchk(`MIA_REG_MDATA, {24'h0, dst ? e[7:0] : b});
            rdchk(`MIA_REG_STATUS, {26'h0, e[13:8]});
        end
        $display("arithmetic and logic test done");
        for (int i = 0; i < 8; i++) begin
            lf = nxt(lf);
            b = lf[7:0];
            wr(`MIA_REG_MADDR, 32'h40);
            wr(`MIA_REG_MDATA, {24'h0, b});
            run(cmdw(0, 4, 1, 1, i, 64, 0), 1, pc + 12'h001);
            rdchk(`MIA_REG_MDATA, {24'h0, b | (8'h01 << i)});
            run(cmdw(0, 4, 2, 0, i, 64, 0), 1, pc + 12'h001);
            run(cmdw(0, 4, 0, 1, i, 64, 0), 1, pc + 12'h001);
            rdchk(`MIA_REG_MDATA, {24'h0, b & ~(8'h01 << i)});
            run(cmdw(0, 4, 2, 0, i, 64, 0), 2, pc + 12'h002);
        end
        wr(`MIA_REG_MADDR, 32'h43);
        wr(`MIA_REG_MDATA, 32'hff);
        run(cmdw(0, 5, 2, 1, 0, 67, 0), 2, pc + 12'h002);
        rdchk(`MIA_REG_MDATA, 32'h0);
        $display("bit and skip test done");
        // bcd sums 15+27 and 99+01 before adjust; only carry may move
        wr(`MIA_REG_STATUS, 32'h0);
        wr(`MIA_REG_MADDR, 32'h42);
        wr(`MIA_REG_ACC, 32'h3c);
        run(cmdw(0, 3, 3, 1, 0, 66, 0), 1, pc + 12'h001);
        rdchk(`MIA_REG_MDATA, 32'h42);
        wr(`MIA_REG_ACC, 32'h9a);
        run(cmdw(0, 3, 3, 1, 0, 66, 0), 1, pc + 12'h001);
        rdchk(`MIA_REG_MDATA, 32'h0);
        rdchk(`MIA_REG_STATUS, 32'h2);
        wr(`MIA_REG_TPTR, 32'h33);
        wr(`MIA_REG_TDATA, {16'h0, lf});
        wr(`MIA_REG_MADDR, 32'h41);
        run(cmdw(0, 6, 3, 0, 0, 65, 0), 2, pc + 12'h001);
        rdchk(`MIA_REG_MDATA, {24'h0, lf[7:0]});
        rdchk(`MIA_REG_TBLH, {24'h0, lf[15:8]});
        run(cmdw(0, 7, 0, 0, 0, 0, 0), 1, pc + 12'h001);
        run(cmdw(0, 6, 0, 0, 3, 0, 165), 2, 12'h3a5);
        run(cmdw(0, 6, 1, 0, 1, 0, 35), 2, 12'h123);
        run(cmdw(0, 6, 2, 0, 0, 0, 0), 2, 12'h3a6);
        wr(`MIA_REG_ACC, 32'h5c);
        run(cmdw(0, 3, 0, 1, 0, 6, 0), 2, {pc[11:8], 8'h5c});
        $display("flow and table test done");
        tally_and_finish;
    end
endmodule // tb_mia_core
